// *** common/interval_timer_pkg.sv ***
// Constants, register map and state types of the two-channel interval timer unit.
package interval_timer_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [31:0] OFS_BASE       = 32'hFFFF83D0;
  localparam logic [31:0] OFS_RUN        = 32'hFFFF83D0;
  localparam logic [31:0] OFS_CSR0       = 32'hFFFF83D2;
  localparam logic [31:0] OFS_CNT0       = 32'hFFFF83D4;
  localparam logic [31:0] OFS_COR0       = 32'hFFFF83D6;
  localparam logic [31:0] OFS_CSR1       = 32'hFFFF83D8;
  localparam logic [31:0] OFS_CNT1       = 32'hFFFF83DA;
  localparam logic [31:0] OFS_COR1       = 32'hFFFF83DC;
  localparam logic [31:0] OFS_IRQ_STATUS = 32'hFFFF83E0;
  localparam logic [31:0] OFS_IRQ_MASK   = 32'hFFFF83E2;

  // Byte address on the bus is four times the byte offset counted from the base.
  localparam int unsigned ADDR_W = 7;
  localparam logic [6:0] ADR_RUN  = 7'((OFS_RUN - OFS_BASE) * 4);
  localparam logic [6:0] ADR_STAT = 7'((OFS_IRQ_STATUS - OFS_BASE) * 4);
  localparam logic [6:0] ADR_MASK = 7'((OFS_IRQ_MASK - OFS_BASE) * 4);
  localparam logic [1:0][6:0] ADR_CSR = {7'((OFS_CSR1 - OFS_BASE) * 4), 7'((OFS_CSR0 - OFS_BASE) * 4)};
  localparam logic [1:0][6:0] ADR_CNT = {7'((OFS_CNT1 - OFS_BASE) * 4), 7'((OFS_CNT0 - OFS_BASE) * 4)};
  localparam logic [1:0][6:0] ADR_COR = {7'((OFS_COR1 - OFS_BASE) * 4), 7'((OFS_COR0 - OFS_BASE) * 4)};

  // ----------------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------------
  localparam int unsigned CSR_FLAG_BIT = 7;
  localparam int unsigned CSR_IE_BIT   = 6;
  localparam logic [15:0] CNT_RST      = 16'h0000;
  localparam logic [15:0] COR_RST      = 16'hFFFF;

  // Clock select codes and prescaler tap masks.
  localparam logic [1:0] CKS_DIV8   = 2'h0;
  localparam logic [1:0] CKS_DIV32  = 2'h1;
  localparam logic [1:0] CKS_DIV128 = 2'h2;
  localparam logic [1:0] CKS_DIV512 = 2'h3;
  localparam logic [8:0] TAP_DIV8   = 9'h007;
  localparam logic [8:0] TAP_DIV32  = 9'h01F;
  localparam logic [8:0] TAP_DIV128 = 9'h07F;
  localparam logic [8:0] TAP_DIV512 = 9'h1FF;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DONE = 2'b10
  } bus_state_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] cor;
    logic        flag;
    logic        ie;
    logic [1:0]  cks;
    logic        seen;
  } chan_t;

  typedef struct packed {
    bus_state_t      bus_st;
    logic [31:0]     rdata;
    logic [8:0]      pre;
    logic [1:0]      run;
    chan_t [1:0]     ch;
    logic [1:0]      irq_status;
    logic [1:0]      irq_mask;
    logic [1:0]      ch_irq;
    logic            irq;
  } state_t;

endpackage

// *** verilog/interval_timer_unit.sv ***
// Two-channel compare match interval timer with an Avalon-MM register slave.
module interval_timer_unit
  import interval_timer_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              standby,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  output logic      [1:0]        match_irq,
  output logic                   irq
);

  // ----------------------------------------------------------------------
  // State and next state
  // ----------------------------------------------------------------------
  state_t      st_ff;
  state_t      nxt_st;
  logic [31:0] rd_mux;
  logic        wr_done;
  logic        rd_done;
  logic [1:0]  tick_w;
  logic [1:0]  match_w;
  logic [1:0]  cnt_we_lo;
  logic [1:0]  cnt_we_hi;
  logic [8:0]  tap_w [2];

  // Merges the enabled bytes of a write into a 16-bit register value.
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] wd,
                                          input logic [1:0]  be);
    merge16 = {be[1] ? wd[15:8] : old_v[15:8], be[0] ? wd[7:0] : old_v[7:0]};
  endfunction

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------

  // Computes the whole next state from the current state, the bus and standby.
  always_comb begin
    nxt_st = st_ff;
    rd_mux = 32'h00000000;
    wr_done = avs_write && (st_ff.bus_st == BUS_DONE);
    rd_done = avs_read && (st_ff.bus_st == BUS_DONE);
    tick_w = 2'b00;
    match_w = 2'b00;
    cnt_we_lo = 2'b00;
    cnt_we_hi = 2'b00;
    tap_w[0] = TAP_DIV8;
    tap_w[1] = TAP_DIV8;

    // Read data; registers are 16 bits wide and reserved bits read 0.
    if (avs_address == ADR_RUN) begin
      rd_mux = {30'h00000000, st_ff.run};
    end
    if (avs_address == ADR_STAT) begin
      rd_mux = {30'h00000000, st_ff.irq_status};
    end
    if (avs_address == ADR_MASK) begin
      rd_mux = {30'h00000000, st_ff.irq_mask};
    end
    for (int i = 0; i < 2; i++) begin
      if (avs_address == ADR_CSR[i]) begin
        rd_mux = {24'h000000, st_ff.ch[i].flag, st_ff.ch[i].ie, 4'h0, st_ff.ch[i].cks};
      end
      if (avs_address == ADR_CNT[i]) begin
        rd_mux = {16'h0000, st_ff.ch[i].cnt};
      end
      if (avs_address == ADR_COR[i]) begin
        rd_mux = {16'h0000, st_ff.ch[i].cor};
      end
    end

    // Bus handshake: one wait cycle, then the access completes.
    case (st_ff.bus_st)
      BUS_IDLE: begin
        if (avs_read || avs_write) begin
          nxt_st.bus_st = BUS_DONE;
          nxt_st.rdata = rd_mux;
        end
      end
      BUS_DONE: begin
        nxt_st.bus_st = BUS_IDLE;
      end
      default: begin
        nxt_st.bus_st = BUS_IDLE;
      end
    endcase

    // Free-running prescaler shared by both channels.
    nxt_st.pre = st_ff.pre + 9'h001;

    // Run select and interrupt mask writes through the low byte lane.
    if (wr_done && avs_byteenable[0] && (avs_address == ADR_RUN)) begin
      nxt_st.run = avs_writedata[1:0];
    end
    if (wr_done && avs_byteenable[0] && (avs_address == ADR_MASK)) begin
      nxt_st.irq_mask = avs_writedata[1:0];
    end
    if (wr_done && avs_byteenable[0] && (avs_address == ADR_STAT)) begin
      nxt_st.irq_status = st_ff.irq_status & ~avs_writedata[1:0];
    end

    // Each channel runs on its own clock select and run bit.
    for (int i = 0; i < 2; i++) begin
      case (st_ff.ch[i].cks)
        CKS_DIV8:   tap_w[i] = TAP_DIV8;
        CKS_DIV32:  tap_w[i] = TAP_DIV32;
        CKS_DIV128: tap_w[i] = TAP_DIV128;
        CKS_DIV512: tap_w[i] = TAP_DIV512;
        default:    tap_w[i] = TAP_DIV8;
      endcase
      tick_w[i] = st_ff.run[i] && ((st_ff.pre & tap_w[i]) == tap_w[i]);
      match_w[i] = tick_w[i] && (st_ff.ch[i].cnt == st_ff.ch[i].cor);
      cnt_we_lo[i] = wr_done && (avs_address == ADR_CNT[i]) && avs_byteenable[0];
      cnt_we_hi[i] = wr_done && (avs_address == ADR_CNT[i]) && avs_byteenable[1];

      // Counter: match clear beats write, write beats increment.
      if (match_w[i]) begin
        nxt_st.ch[i].cnt = CNT_RST;
      end else if (cnt_we_lo[i] || cnt_we_hi[i]) begin
        nxt_st.ch[i].cnt = merge16(st_ff.ch[i].cnt, avs_writedata[15:0],
                                   {cnt_we_hi[i], cnt_we_lo[i]});
      end else if (tick_w[i]) begin
        nxt_st.ch[i].cnt = st_ff.ch[i].cnt + 16'h0001;
      end

      // Compare constant write by byte lanes.
      if (wr_done && (avs_address == ADR_COR[i])) begin
        nxt_st.ch[i].cor = merge16(st_ff.ch[i].cor, avs_writedata[15:0], avs_byteenable[1:0]);
      end

      // A read that returned the flag as 1 arms the clear.
      if (rd_done && (avs_address == ADR_CSR[i]) && st_ff.rdata[CSR_FLAG_BIT]) begin
        nxt_st.ch[i].seen = 1'b1;
      end

      // Control/status write; only a 0 after an armed read clears the flag.
      if (wr_done && (avs_address == ADR_CSR[i]) && avs_byteenable[0]) begin
        nxt_st.ch[i].ie = avs_writedata[CSR_IE_BIT];
        nxt_st.ch[i].cks = avs_writedata[1:0];
        if (!avs_writedata[CSR_FLAG_BIT] && st_ff.ch[i].seen) begin
          nxt_st.ch[i].flag = 1'b0;
          nxt_st.ch[i].seen = 1'b0;
        end
      end

      // A match sets the flag and the sticky status; the set wins over a clear.
      if (match_w[i]) begin
        nxt_st.ch[i].flag = 1'b1;
        nxt_st.irq_status[i] = 1'b1;
      end
    end

    // Standby puts run select and the channel registers back to their initial values; status and mask keep theirs.
    if (standby) begin
      nxt_st.run = 2'b00;
      for (int i = 0; i < 2; i++) begin
        nxt_st.ch[i].cnt = CNT_RST;
        nxt_st.ch[i].cor = COR_RST;
        nxt_st.ch[i].flag = 1'b0;
        nxt_st.ch[i].ie = 1'b0;
        nxt_st.ch[i].cks = CKS_DIV8;
        nxt_st.ch[i].seen = 1'b0;
      end
    end

    // Per-channel requests and the combined masked interrupt.
    for (int i = 0; i < 2; i++) begin
      nxt_st.ch_irq[i] = nxt_st.ch[i].flag && nxt_st.ch[i].ie;
    end
    nxt_st.irq = |(nxt_st.irq_status & nxt_st.irq_mask);
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------

  // Registers the state; reset loads the initial register values.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_ff <= '0;
      st_ff.bus_st <= BUS_IDLE;
      st_ff.ch[0].cor <= COR_RST;
      st_ff.ch[1].cor <= COR_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs come straight from state flip-flops.
  assign avs_readdata    = st_ff.rdata;
  assign avs_waitrequest = st_ff.bus_st[0];
  assign match_irq       = st_ff.ch_irq;
  assign irq             = st_ff.irq;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // A request is held one cycle with waitrequest high, then completes.
  sequence s_req_seen;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_req_done;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  a_bus_one_wait: assert property (s_req_seen |=> s_req_done)
    else $error("Bus access did not complete after one wait cycle.");

  a_reserved_zero: assert property (rd_done && (avs_address == ADR_CSR[0] ||
      avs_address == ADR_CSR[1]) |-> (avs_readdata[31:8] == 24'h000000) &&
      (avs_readdata[5:2] == 4'h0))
    else $error("Reserved control/status bits read nonzero.");

  a_standby_init: assert property (standby |=> st_ff.run == 2'b00 &&
      st_ff.ch[0].cnt == CNT_RST && st_ff.ch[1].cor == COR_RST &&
      st_ff.ch[0].cor == COR_RST && !st_ff.ch[1].ie)
    else $error("Standby did not restore initial values.");

  // ----------------------------------------------------------------------
  // Register access checks
  // ----------------------------------------------------------------------

  // Waitrequest drops for exactly one cycle per access.
  a_wait_pulse: assert property (!avs_waitrequest
      |=> avs_waitrequest)
    else $error("Waitrequest stayed low for more than one cycle.");

  // Every register is 16 bits wide, so the upper half of read data is zero.
  a_upper_zero: assert property (!avs_waitrequest
      |-> avs_readdata[31:16] == 16'h0000)
    else $error("Upper read data half is nonzero.");

  // Reserved run select bits read as zero.
  a_run_reserved: assert property (rd_done && (avs_address == ADR_RUN)
      |-> avs_readdata[31:2] == 30'h0000000)
    else $error("Reserved run select bits read nonzero.");

  // Only the two status bits can read as one.
  a_stat_reserved: assert property (rd_done && (avs_address == ADR_STAT)
      |-> avs_readdata[31:2] == 30'h0000000)
    else $error("Reserved status bits read nonzero.");

  // A low-lane write to run select loads both run bits.
  a_run_write: assert property (wr_done && avs_byteenable[0] && (avs_address == ADR_RUN) &&
      !standby |=> st_ff.run == $past(avs_writedata[1:0]))
    else $error("Run select write did not take effect.");

  // A low-lane write to the mask loads both mask bits.
  a_mask_write: assert property (wr_done && avs_byteenable[0] && (avs_address == ADR_MASK)
      |=> st_ff.irq_mask == $past(avs_writedata[1:0]))
    else $error("Interrupt mask write did not take effect.");

  // The shared line is high exactly while an unmasked status bit is set.
  a_irq_level: assert property (irq == |(st_ff.irq_status & st_ff.irq_mask))
    else $error("Shared interrupt does not follow status and mask.");

  for (genvar g = 0; g < 2; g++) begin : g_chk
    a_match_clears: assert property (match_w[g] && !standby |=> st_ff.ch[g].cnt == CNT_RST &&
        st_ff.ch[g].flag)
      else $error("Match did not clear the counter and set the flag.");

    a_count_step: assert property (tick_w[g] && !match_w[g] && !cnt_we_lo[g] &&
        !cnt_we_hi[g] && !standby |=> st_ff.ch[g].cnt == $past(st_ff.ch[g].cnt) + 16'h0001)
      else $error("Counter did not step on its clock pulse.");

    a_wait_for_tick: assert property (!tick_w[g] && !cnt_we_lo[g] && !cnt_we_hi[g] &&
        !standby |=> $stable(st_ff.ch[g].cnt))
      else $error("Counter changed without a clock pulse or write.");

    a_div_tap: assert property (tick_w[g] && st_ff.ch[g].cks == CKS_DIV512 |->
        st_ff.pre == TAP_DIV512 && st_ff.run[g])
      else $error("Divide by 512 pulse at wrong prescaler phase.");

    a_write_wins: assert property (!match_w[g] && cnt_we_lo[g] && !cnt_we_hi[g] &&
        !standby |=> st_ff.ch[g].cnt == {$past(st_ff.ch[g].cnt[15:8]),
        $past(avs_writedata[7:0])})
      else $error("Byte write to counter lost or incremented.");

    a_flag_holds: assert property (st_ff.ch[g].flag && !st_ff.ch[g].seen && !standby |=>
        st_ff.ch[g].flag)
      else $error("Match flag cleared without a prior read.");

    a_irq_follows: assert property (st_ff.ch[g].flag && st_ff.ch[g].ie && !standby
        ##1 st_ff.ch[g].flag && st_ff.ch[g].ie |-> match_irq[g])
      else $error("Channel interrupt not raised for enabled flag.");

    // A completed low-lane write of this channel's control/status.
    sequence s_csr_write;
      wr_done && avs_byteenable[0] && (avs_address == ADR_CSR[g]) && !standby;
    endsequence

    // A completed word write of this channel's counter with no match pending.
    sequence s_cnt_word_write;
      cnt_we_lo[g] && cnt_we_hi[g] && !match_w[g] && !standby;
    endsequence

    // The channel request is the registered AND of flag and enable.
    a_chan_irq_level: assert property (match_irq[g] ==
        (st_ff.ch[g].flag && st_ff.ch[g].ie))
      else $error("Channel request does not follow flag and enable.");

    // A match that meets a counter write still clears the counter.
    a_clear_beats_write: assert property (match_w[g] && (cnt_we_lo[g] || cnt_we_hi[g]) &&
        !standby |=> st_ff.ch[g].cnt == CNT_RST)
      else $error("Counter write won over a match clear.");

    // A word write loads the counter with no increment.
    a_word_write: assert property (s_cnt_word_write
        |=> st_ff.ch[g].cnt == $past(avs_writedata[15:0]))
      else $error("Counter word write lost or incremented.");

    // A high byte write keeps the low byte unchanged and unincremented.
    a_hi_byte_write: assert property (!match_w[g] && !cnt_we_lo[g] && cnt_we_hi[g] &&
        !standby |=> st_ff.ch[g].cnt == {$past(avs_writedata[15:8]),
        $past(st_ff.ch[g].cnt[7:0])})
      else $error("Counter high byte write lost or incremented.");

    // A halted counter only changes by a write or by standby.
    a_halt_holds: assert property (!st_ff.run[g] && !cnt_we_lo[g] && !cnt_we_hi[g] &&
        !standby |=> $stable(st_ff.ch[g].cnt))
      else $error("Halted counter changed.");

    // A counter read returns the value held when the access was taken.
    a_cnt_readback: assert property (rd_done && (avs_address == ADR_CNT[g])
        |-> avs_readdata == {16'h0000, $past(st_ff.ch[g].cnt)})
      else $error("Counter read returned a wrong value.");

    // A full write of the compare constant loads it.
    a_cor_write: assert property (wr_done && (avs_address == ADR_COR[g]) &&
        (avs_byteenable[1:0] == 2'b11) && !standby
        |=> st_ff.ch[g].cor == $past(avs_writedata[15:0]))
      else $error("Compare constant write did not take effect.");

    // The enable bit follows a control/status write.
    a_ie_write: assert property (s_csr_write
        |=> st_ff.ch[g].ie == $past(avs_writedata[CSR_IE_BIT]))
      else $error("Interrupt enable write did not take effect.");

    // The clock select field follows a control/status write.
    a_cks_write: assert property (s_csr_write
        |=> st_ff.ch[g].cks == $past(avs_writedata[1:0]))
      else $error("Clock select write did not take effect.");

    // Flag and enable read back from their own bit positions.
    a_csr_readback: assert property (rd_done && (avs_address == ADR_CSR[g])
        |-> avs_readdata[7:6] == $past({st_ff.ch[g].flag, st_ff.ch[g].ie}))
      else $error("Control/status read returned wrong flag or enable.");

    // A read that shows the flag set arms the clear.
    a_seen_arms: assert property (rd_done && (avs_address == ADR_CSR[g]) &&
        avs_readdata[CSR_FLAG_BIT] && !standby |=> st_ff.ch[g].seen)
      else $error("Flag read as one did not arm the clear.");

    // A zero written after an arming read clears the flag.
    a_flag_clears: assert property (s_csr_write ##0 (!avs_writedata[CSR_FLAG_BIT] &&
        st_ff.ch[g].seen && !match_w[g]) |=> !st_ff.ch[g].flag)
      else $error("Armed zero write did not clear the flag.");

    // Only a match sets the flag; a written one does nothing.
    a_flag_no_set: assert property (!st_ff.ch[g].flag && !match_w[g]
        |=> !st_ff.ch[g].flag)
      else $error("Match flag set without a match.");

    // A match sets the sticky status bit of its channel.
    a_status_sets: assert property (match_w[g]
        |=> st_ff.irq_status[g])
      else $error("Match did not set the status bit.");

    // Writing a one clears the status bit unless a match comes at once.
    a_status_clear: assert property (wr_done && avs_byteenable[0] && (avs_address == ADR_STAT) &&
        avs_writedata[g] && !match_w[g] |=> !st_ff.irq_status[g])
      else $error("Status bit did not clear on a written one.");

    // Standby returns every channel register to its initial value.
    a_standby_chan: assert property (standby |=> st_ff.ch[g].cnt == CNT_RST &&
        st_ff.ch[g].cor == COR_RST && !st_ff.ch[g].flag && !st_ff.ch[g].ie &&
        st_ff.ch[g].cks == CKS_DIV8)
      else $error("Standby did not restore the channel registers.");
  end

endmodule

// *** verification/tb_interval_timer_unit.sv ***
// Self-checking testbench of the two-channel interval timer unit.
module tb_interval_timer_unit
  import interval_timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------------
  // Signals and counters
  // ----------------------------------------------------------------------
  logic              clk_sys;
  logic              reset;
  logic              standby;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [31:0]       avs_writedata;
  logic [3:0]        avs_byteenable;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic [1:0]        match_irq;
  logic              irq;
  int                error_cnt;
  int                checks_done;
  int                cyc;
  logic [31:0]       lfsr_st;
  logic [31:0]       q;

  interval_timer_unit DUT (
    .clk_sys         (clk_sys),
    .reset           (reset),
    .standby         (standby),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .match_irq       (match_irq),
    .irq             (irq)
  );

  // ----------------------------------------------------------------------
  // Clock, cycle count and watchdog
  // ----------------------------------------------------------------------
  // The clock toggles every 5 ns for a 100 MHz rate.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // The cycle count measures how long a channel was left running.
  always @(posedge clk_sys) cyc <= cyc + 1;

  // The watchdog ends a hung run well after the tests should have ended.
  initial begin
    #400us;
    error_cnt++;
    results();
  end

  // ----------------------------------------------------------------------
  // Tasks and functions
  // ----------------------------------------------------------------------
  // The compare task reports and counts a mismatch at once.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One Avalon-MM access, held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [6:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address    <= a;
    avs_write      <= wr;
    avs_read       <= !wr;
    avs_writedata  <= d;
    avs_byteenable <= be;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) error_cnt++;
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr16(input logic [6:0] a, input logic [15:0] d);
    logic [31:0] t;
    bus(1'b1, a, {16'h0000, d}, 4'h3, t);
  endtask

  task automatic rd_chk(input string name, input logic [6:0] a, input logic [31:0] exp);
    logic [31:0] t;
    bus(1'b0, a, 32'h0000_0000, 4'hF, t);
    check(name, t, exp);
  endtask

  // Next value of the bench's random source.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction

  // A written control/status value reads back without the flag and reserved bits.
  function automatic logic [31:0] csr_exp(input logic [15:0] d);
    return {16'h0000, d & 16'h0043};
  endfunction

  // A run of len cycles on a divide-by-div clock gives len/div ticks, give or take one.
  function automatic logic ticks_ok(input int len, input int div, input logic [31:0] seen);
    return (int'(seen) >= len / div - 1) && (int'(seen) <= len / div + 1);
  endfunction

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    int divs[4];
    int t0;
    int len;
    divs = '{8, 32, 128, 512};
    {reset, standby, avs_read, avs_write} = 4'b1000;
    {avs_address, avs_writedata, avs_byteenable, cyc} = '0;
    {error_cnt, checks_done} = '0;
    lfsr_st = 32'h9DAECFF3;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    // Register values after reset, and an unmapped address.
    rd_chk("run", ADR_RUN, 32'h0);
    for (int i = 0; i < 2; i++) begin
      rd_chk("csr", ADR_CSR[i], 32'h0);
      rd_chk("cnt", ADR_CNT[i], 32'h0);
      rd_chk("cor", ADR_COR[i], 32'h0000FFFF);
    end
    rd_chk("unmapped", 7'h50, 32'h0);
    // Byte and word writes to a halted counter.
    wr16(ADR_CNT[0], 16'h1234);
    bus(1'b1, ADR_CNT[0], 32'h0000_00AB, 4'h1, q);
    rd_chk("cnt byte lo", ADR_CNT[0], 32'h000012AB);
    bus(1'b1, ADR_CNT[0], 32'hFFFF_5600, 4'h2, q);
    rd_chk("cnt byte hi", ADR_CNT[0], 32'h000056AB);
    // Each clock select code on both channels at once.
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 2; i++) begin
        wr16(ADR_CNT[i], 16'h0000);
        wr16(ADR_CSR[i], {14'h0, 2'(k)});
      end
      wr16(ADR_RUN, 16'h0003);
      t0 = cyc;
      repeat (3 * divs[k]) @(posedge clk_sys);
      wr16(ADR_RUN, 16'h0000);
      len = cyc - t0;
      for (int i = 0; i < 2; i++) begin
        bus(1'b0, ADR_CNT[i], 32'h0, 4'h3, q);
        check("tick count", ticks_ok(len, divs[k], q), 1'b1);
      end
      rd_chk("held cnt", ADR_CNT[0], q);
    end
    // One run bit alone moves only its own channel.
    wr16(ADR_CNT[1], 16'h0000);
    wr16(ADR_RUN, 16'h0001);
    repeat (64) @(posedge clk_sys);
    rd_chk("halted chan1", ADR_CNT[1], 32'h0);
    wr16(ADR_RUN, 16'h0000);
    // Compare match on channel 0 with a short period.
    wr16(ADR_COR[0], 16'h0002);
    wr16(ADR_CNT[0], 16'h0000);
    wr16(ADR_CSR[0], 16'h0040);
    wr16(ADR_RUN, 16'h0001);
    for (int n = 0; n < 200 && match_irq[0] !== 1'b1; n++) @(posedge clk_sys);
    check("match_irq0", match_irq[0], 1'b1);
    check("match_irq1", match_irq[1], 1'b0);
    check("irq masked", irq, 1'b0);
    for (int n = 0; n < 6; n++) begin
      bus(1'b0, ADR_CNT[0], 32'h0, 4'h3, q);
      check("cnt wraps", q <= 32'h2, 1'b1);
    end
    wr16(ADR_RUN, 16'h0000);
    // Flag clear needs a read of one first; a written one does nothing.
    wr16(ADR_CSR[0], 16'h0040);
    rd_chk("flag kept", ADR_CSR[0], 32'h000000C0);
    wr16(ADR_CSR[0], 16'h0040);
    rd_chk("flag cleared", ADR_CSR[0], 32'h00000040);
    check("irq0 dropped", match_irq[0], 1'b0);
    wr16(ADR_CSR[0], 16'h00C0);
    rd_chk("flag not set", ADR_CSR[0], 32'h00000040);
    // Sticky status, mask and the shared interrupt line.
    rd_chk("status", ADR_STAT, 32'h00000001);
    wr16(ADR_MASK, 16'h0001);
    repeat (2) @(posedge clk_sys);
    check("irq on", irq, 1'b1);
    wr16(ADR_MASK, 16'h0000);
    repeat (2) @(posedge clk_sys);
    check("irq masked off", irq, 1'b0);
    wr16(ADR_MASK, 16'h0001);
    wr16(ADR_STAT, 16'h0001);
    repeat (2) @(posedge clk_sys);
    check("irq cleared", irq, 1'b0);
    rd_chk("status cleared", ADR_STAT, 32'h0);
    // Random 32-bit, 16-bit and 8-bit accesses, reserved bits set on purpose.
    for (int n = 0; n < 6; n++) begin
      lfsr_st = lfsr(lfsr_st);
      bus(1'b1, ADR_COR[1], lfsr_st, 4'hF, q);
      rd_chk("cor rand", ADR_COR[1], {16'h0, lfsr_st[15:0]});
      bus(1'b1, ADR_CSR[1], lfsr_st & 32'hFFFFFF7F, 4'h3, q);
      rd_chk("csr rand", ADR_CSR[1], csr_exp(lfsr_st[15:0]));
      bus(1'b1, ADR_RUN, lfsr_st & 32'hFFFFFFFC, 4'h1, q);
      rd_chk("run reserved", ADR_RUN, 32'h0);
    end
    // Standby returns run select and channel registers to their initial values.
    wr16(ADR_CNT[1], 16'h0055);
    wr16(ADR_RUN, 16'h0002);
    standby <= 1'b1;
    repeat (3) @(posedge clk_sys);
    standby <= 1'b0;
    rd_chk("run sb", ADR_RUN, 32'h0);
    rd_chk("csr sb", ADR_CSR[1], 32'h0);
    rd_chk("cnt sb", ADR_CNT[1], 32'h0);
    rd_chk("cor sb", ADR_COR[1], 32'h0000FFFF);
    rd_chk("cor0 sb", ADR_COR[0], 32'h0000FFFF);
    results();
  end
endmodule
